// *** rtl/crane_interlock.sv ***
`timescale 1ns/100ps
module crane_interlock
  import crane_pkg::*;
#(
  parameter int TRIP_CYCLES = BOOM_TRIP_CYCLES
) (
  input  wire logic                    clk,                // System clock
  input  wire logic                    srst,               // Sync reset
  input  wire logic [7:0]              awaddr,             // Write address
  input  wire logic                    awvalid,            // Write address valid
  output logic                         awready,            // Write address ready
  input  wire logic [31:0]             wdata,              // Write data
  input  wire logic [3:0]              wstrb,              // Byte strobes
  input  wire logic                    wvalid,             // Write data valid
  output logic                         wready,             // Write data ready
  output logic [1:0]                   bresp,              // Write response
  output logic                         bvalid,             // Write response valid
  input  wire logic                    bready,             // Write response ready
  input  wire logic [7:0]              araddr,             // Read address
  input  wire logic                    arvalid,            // Read address valid
  output logic                         arready,            // Read address ready
  output logic [31:0]                  rdata,              // Read data
  output logic [1:0]                   rresp,              // Read response
  output logic                         rvalid,             // Read data valid
  input  wire logic                    rready,             // Read data ready
  input  wire logic                    load_sensor_closed, // High while not overloaded
  input  wire logic                    anti_two_block_switch, // High while closed
  input  wire function_set_t           toggles,            // Operator toggle requests
  input  wire link_status_t            link,               // Transmitter and line status
  input  wire logic [SENSOR_CODES-1:0] sensor_faults,      // Sensor faults 04..09
  input  wire logic [OUT_CODES-1:0]    output_faults,      // Output faults 10..18
  output function_set_t                fn_out,             // Function outputs
  output logic                         pump,               // Pump solenoid
  output logic [CODE_W-1:0]            active_codes,       // Stored codes, bit = code
  output logic [CODE_W-1:0]            histogram_codes,    // Histogram view
  output logic                         irq                 // Level interrupt
);

  if (TRIP_CYCLES < 1) begin : g_bad_trip
    $error("TRIP_CYCLES must be at least one");
  end

  logic [1:0]        ctrl;
  logic [IRQ_W-1:0]  irq_stat;
  logic [IRQ_W-1:0]  irq_mask;
  logic [CODE_W-1:0] code_set;
  logic [CODE_W-1:0] code_clr;
  logic [CODE_W-1:0] sw_clr;
  logic              overload;
  logic              two_block;
  logic              boom_trip;
  logic              overload_q;
  logic              two_block_q;
  logic              sensor_block;
  logic              sensor_block_bd;
  logic              toggles_neutral;
  function_set_t     next_fn;
  function_set_t     pump_fns;

  // Both safety switches are closed in normal service
  assign overload  = !load_sensor_closed;
  assign two_block = !anti_two_block_switch;
  assign toggles_neutral = (toggles == '0);

  // Overload must persist before boom down is cut
  trip_delay #(
    .DELAY_CYCLES (TRIP_CYCLES)
  ) u_boom_trip (
    .clk      (clk),
    .srst     (srst),
    .raw      (overload),
    .filtered (boom_trip)
  );

  // Sensor codes stop the limiting functions; code 06 may spare boom down
  always_comb begin
    sensor_block    = |active_codes[CODE_SENSOR_HI:CODE_SENSOR_LO];
    sensor_block_bd = sensor_block;
    if (ctrl[CTRL_CHASSIS_LIMIT] && active_codes[CODE_CHASSIS_SIX]) begin
      sensor_block_bd = |(active_codes[CODE_SENSOR_HI:CODE_SENSOR_LO]
                          & ~(SENSOR_CODES'(1) << (CODE_CHASSIS_SIX - CODE_SENSOR_LO)));
    end
  end

  // Interlock on the requested functions
  always_comb begin
    next_fn = toggles; // Safe directions and rotation pass through
    next_fn.hoist_up  = toggles.hoist_up && !toggles.hoist_down
                        && !overload && !two_block && !sensor_block;
    next_fn.hoist_down = toggles.hoist_down && !toggles.hoist_up;
    next_fn.ext_out   = toggles.ext_out && !overload && !two_block && !sensor_block;
    next_fn.boom_down = toggles.boom_down && !boom_trip && !sensor_block_bd
                        && !(two_block && !ctrl[CTRL_WINCH_ON_BOOM]);
    pump_fns      = next_fn;
    pump_fns.horn = 1'b0; // Horn needs no pump
  end

  // Registered outputs; neither hoist solenoid is driven while both hoist directions are requested
  always_ff @(posedge clk) begin
    if (srst) begin
      fn_out <= '0;
      pump   <= 1'b0;
    end else begin
      fn_out <= next_fn;
      pump   <= |pump_fns;
    end
  end

  // Fault raising and clearing conditions per code
  always_comb begin
    code_set = '0;
    code_clr = sw_clr;
    code_set[CODE_SENSOR_HI:CODE_SENSOR_LO] = sensor_faults; // Only software clears
    code_set[CODE_OUT_HI:CODE_OUT_LO]       = output_faults;
    code_clr[CODE_OUT_HI:CODE_OUT_LO]       = sw_clr[CODE_OUT_HI:CODE_OUT_LO] | toggles;
    code_set[CODE_ESTOP]      = link.estop_open && !link.transmitter_on;
    code_clr[CODE_ESTOP]      = sw_clr[CODE_ESTOP] || link.transmitter_on;
    code_set[CODE_SPEED]      = link.speed_open;
    code_set[CODE_TRIGGER]    = link.trigger_lost;
    code_set[CODE_TRIG_EARLY] = link.trigger_held && toggles_neutral;
    code_clr[CODE_TRIG_EARLY] = sw_clr[CODE_TRIG_EARLY] || !link.trigger_held;
  end

  // One sticky flag per fault code
  for (genvar i = 0; i < CODE_W; i++) begin : g_code
    if (i >= CODE_SENSOR_LO && i <= CODE_TRIG_EARLY) begin : g_flag
      fault_flag u_flag (
        .clk  (clk),
        .srst (srst),
        .set  (code_set[i]),
        .clr  (code_clr[i]),
        .q    (active_codes[i])
      );
    end else begin : g_none
      assign active_codes[i] = 1'b0;
    end
  end

  // Histogram: trigger-early only with a toggle thrown, the rest in neutral
  always_ff @(posedge clk) begin
    if (srst) begin
      histogram_codes <= '0;
    end else if (toggles_neutral) begin
      histogram_codes <= active_codes & ~(CODE_W'(1) << CODE_TRIG_EARLY);
    end else begin
      histogram_codes <= active_codes & (CODE_W'(1) << CODE_TRIG_EARLY);
    end
  end

  // Register bus slave
  logic              aw_full;
  logic              w_full;
  logic [7:0]        aw_addr;
  logic [31:0]       w_data;
  logic [31:0]       w_mask;
  logic              wr_do;
  logic              wr_hit;
  logic              next_aw_full;
  logic              next_w_full;
  logic              next_bvalid;
  logic              next_rvalid;
  logic              ar_take;
  logic [31:0]       rd_word;
  logic              rd_hit;
  logic [31:0]       wr_bits;
  logic [IRQ_W-1:0]  irq_event;

  // Address and data are held separately; the write happens once both are in
  assign wr_do       = aw_full && w_full;
  assign wr_bits     = w_data & w_mask;
  assign next_aw_full = wr_do ? 1'b0 : (aw_full || (awvalid && awready));
  assign next_w_full  = wr_do ? 1'b0 : (w_full || (wvalid && wready));
  assign next_bvalid  = wr_do || (bvalid && !bready);
  assign ar_take      = arvalid && arready;
  assign next_rvalid  = ar_take || (rvalid && !rready);
  assign wr_hit = (aw_addr == ADDR_CTRL) || (aw_addr == ADDR_FAULTS)
                  || (aw_addr == ADDR_IRQ_STAT) || (aw_addr == ADDR_IRQ_MASK);
  assign sw_clr = (wr_do && aw_addr == ADDR_FAULTS) ? wr_bits : '0;

  // Channel holding and ready flops
  always_ff @(posedge clk) begin
    if (srst) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      awready <= 1'b0;
      wready  <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= RESP_OKAY;
    end else begin
      aw_full <= next_aw_full;
      w_full  <= next_w_full;
      awready <= !next_aw_full && !next_bvalid;
      wready  <= !next_w_full && !next_bvalid;
      bvalid  <= next_bvalid;
      if (wr_do) begin
        bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Payload capture
  always_ff @(posedge clk) begin
    if (awvalid && awready) begin
      aw_addr <= awaddr;
    end
    if (wvalid && wready) begin
      w_data <= wdata;
      w_mask <= {{8{wstrb[3]}}, {8{wstrb[2]}}, {8{wstrb[1]}}, {8{wstrb[0]}}};
    end
  end

  // Software-written configuration
  always_ff @(posedge clk) begin
    if (srst) begin
      ctrl     <= CTRL_RESET;
      irq_mask <= MASK_RESET;
    end else if (wr_do) begin
      if (aw_addr == ADDR_CTRL && wstrb_ok(w_mask)) begin
        ctrl <= w_data[1:0];
      end
      if (aw_addr == ADDR_IRQ_MASK && wstrb_ok(w_mask)) begin
        irq_mask <= w_data[IRQ_W-1:0];
      end
    end
  end

  function automatic logic wstrb_ok(input logic [31:0] m);
    return m[0];
  endfunction : wstrb_ok

  // Interrupt events: new trips and newly raised codes
  assign irq_event = {|(code_set & ~active_codes), two_block && !two_block_q,
                      overload && !overload_q};

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk) begin
    if (srst) begin
      irq_stat    <= '0;
      overload_q  <= 1'b0;
      two_block_q <= 1'b0;
      irq         <= 1'b0;
    end else begin
      overload_q  <= overload;
      two_block_q <= two_block;
      if (wr_do && aw_addr == ADDR_IRQ_STAT) begin
        irq_stat <= (irq_stat & ~wr_bits[IRQ_W-1:0]) | irq_event;
      end else begin
        irq_stat <= irq_stat | irq_event;
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case (araddr)
      ADDR_CTRL:     rd_word[1:0] = ctrl;
      ADDR_LIVE:     rd_word[LIVE_BOOM_TRIP:LIVE_OVERLOAD] = {boom_trip, two_block, overload};
      ADDR_FAULTS:   rd_word = active_codes;
      ADDR_HISTO:    rd_word = histogram_codes;
      ADDR_IRQ_STAT: rd_word[IRQ_W-1:0] = irq_stat;
      ADDR_IRQ_MASK: rd_word[IRQ_W-1:0] = irq_mask;
      default:       rd_hit = 1'b0;
    endcase
  end

  // Read channel; data are a snapshot taken at the address handshake
  always_ff @(posedge clk) begin
    if (srst) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else begin
      arready <= !next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take) begin
        rdata <= rd_word;
        rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // Checks
  property p_block_damage;
    @(posedge clk) disable iff (srst)
      (overload || two_block) |=> !fn_out.hoist_up && !fn_out.ext_out;
  endproperty
  a_block_damage: assert property (p_block_damage) else $error("damaging motion not blocked");

  property p_safe_moves;
    @(posedge clk) disable iff (srst)
      (overload && toggles.boom_up && toggles.ext_in) |=> fn_out.boom_up && fn_out.ext_in;
  endproperty
  a_safe_moves: assert property (p_safe_moves) else $error("safe motion lost on overload");

  property p_winch_on_boom;
    @(posedge clk) disable iff (srst)
      (two_block && ctrl[CTRL_WINCH_ON_BOOM] && !boom_trip && !sensor_block && toggles.boom_down)
      |=> fn_out.boom_down;
  endproperty
  a_winch_on_boom: assert property (p_winch_on_boom) else $error("two-block cut boom down");

  property p_spike;
    @(posedge clk) disable iff (srst) $rose(overload) |=> !boom_trip ##1 !boom_trip;
  endproperty
  a_spike: assert property (p_spike) else $error("boom trip without delay");

  property p_no_overlap;
    @(posedge clk) disable iff (srst) !(fn_out.hoist_up && fn_out.hoist_down);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("both hoist solenoids on");

  property p_pump;
    @(posedge clk) disable iff (srst)
      (fn_out.boom_up || fn_out.hoist_down || fn_out.rot_cw) |-> pump;
  endproperty
  a_pump: assert property (p_pump) else $error("pump off with function active");

  property p_toggle_clear;
    @(posedge clk) disable iff (srst)
      (toggles.horn && !output_faults[0]) |=> !active_codes[CODE_OUT_LO];
  endproperty
  a_toggle_clear: assert property (p_toggle_clear) else $error("output code not cleared");

  property p_hist_neutral;
    @(posedge clk) disable iff (srst)
      !toggles_neutral |=> histogram_codes[CODE_TRIG_EARLY-1:0] == '0;
  endproperty
  a_hist_neutral: assert property (p_hist_neutral) else $error("histogram shown off neutral");

  property p_estop;
    @(posedge clk) disable iff (srst) link.transmitter_on |=> !active_codes[CODE_ESTOP];
  endproperty
  a_estop: assert property (p_estop) else $error("e-stop code with transmitter on");

endmodule : crane_interlock

// *** rtl/crane_pkg.sv ***
package crane_pkg;

  // Clock and the boom-down trip filter time
  localparam int CLK_PERIOD_NS      = 100;
  localparam int BOOM_TRIP_DELAY_NS = 1_000_000_000;
  localparam int BOOM_TRIP_CYCLES   = (BOOM_TRIP_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_LIVE     = 8'h04;
  localparam logic [7:0] ADDR_FAULTS   = 8'h08;
  localparam logic [7:0] ADDR_HISTO    = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Field positions
  localparam int CTRL_WINCH_ON_BOOM = 0;
  localparam int CTRL_CHASSIS_LIMIT = 1;
  localparam int LIVE_OVERLOAD      = 0;
  localparam int LIVE_TWO_BLOCK     = 1;
  localparam int LIVE_BOOM_TRIP     = 2;
  localparam int IRQ_OVERLOAD       = 0;
  localparam int IRQ_TWO_BLOCK      = 1;
  localparam int IRQ_FAULT          = 2;
  localparam int IRQ_W              = 3;

  // Reset values
  localparam logic [1:0]       CTRL_RESET = 2'h0;
  localparam logic [IRQ_W-1:0] MASK_RESET = 3'h0;

  // Fault code numbers, one bit per code in the code vector
  localparam int CODE_W           = 32;
  localparam int CODE_SENSOR_LO   = 4;
  localparam int CODE_SENSOR_HI   = 9;
  localparam int CODE_CHASSIS_SIX = 6;
  localparam int CODE_OUT_LO      = 10;
  localparam int CODE_OUT_HI      = 18;
  localparam int CODE_ESTOP       = 19;
  localparam int CODE_SPEED       = 20;
  localparam int CODE_TRIGGER     = 23;
  localparam int CODE_TRIG_EARLY  = 24;
  localparam int SENSOR_CODES     = CODE_SENSOR_HI - CODE_SENSOR_LO + 1;
  localparam int OUT_CODES        = CODE_OUT_HI - CODE_OUT_LO + 1;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Function set; bit i pairs with output fault code CODE_OUT_LO + i
  typedef struct packed {
    logic hoist_down;
    logic hoist_up;
    logic boom_down;
    logic boom_up;
    logic ext_in;
    logic ext_out;
    logic rot_ccw;
    logic rot_cw;
    logic horn;
  } function_set_t;

  // Transmitter and output line status
  typedef struct packed {
    logic transmitter_on;
    logic estop_open;
    logic speed_open;
    logic trigger_lost;
    logic trigger_held;
  } link_status_t;

endpackage : crane_pkg

// *** rtl/fault_flag.sv ***
`timescale 1ns/100ps
module fault_flag
  import crane_pkg::*;
(
  input  wire logic clk,  // System clock
  input  wire logic srst, // Sync reset
  input  wire logic set,  // Fault detected
  input  wire logic clr,  // Clearing condition
  output logic      q     // Stored code
);

  // Set beats clear so a fault in the clearing cycle survives
  always_ff @(posedge clk) begin
    if (srst) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule : fault_flag

// *** rtl/trip_delay.sv ***
`timescale 1ns/100ps
module trip_delay
  import crane_pkg::*;
#(
  parameter int DELAY_CYCLES = BOOM_TRIP_CYCLES
) (
  input  wire logic clk,      // System clock
  input  wire logic srst,     // Sync reset
  input  wire logic raw,      // Unfiltered trip
  output logic      filtered  // Trip held long enough
);

  localparam int CW = $clog2(DELAY_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(DELAY_CYCLES - 1);

  if (DELAY_CYCLES < 1) begin : g_bad_delay
    $error("trip_delay needs at least one cycle");
  end

  logic [CW-1:0] count;

  // Any drop of the trip restarts the wait, which rejects spikes
  always_ff @(posedge clk) begin
    if (srst || !raw) begin
      count    <= '0;
      filtered <= 1'b0;
    end else if (count == LAST) begin
      filtered <= 1'b1;
    end else begin
      count <= count + CW'(1);
    end
  end

  property p_trip_drop;
    @(posedge clk) disable iff (srst) !raw |=> !filtered;
  endproperty
  a_trip_drop: assert property (p_trip_drop) else $error("trip kept after input cleared");

endmodule : trip_delay

// *** tb/crane_far_side.sv ***
`timescale 1ns/100ps
module crane_far_side
  import crane_pkg::*;
(
  input  wire logic weight_lifted, // Hook raises the block weight
  input  wire logic over_press,    // Cylinder pressure above rating
  output logic      load_closed,   // Load sensor contact
  output logic      block_closed   // Block switch contact
);
  // Both contacts sit closed in service and open on a trip
  assign load_closed = ~over_press;
  assign block_closed = ~weight_lifted; // Weight holds the lever shut
endmodule : crane_far_side

// *** tb/crane_safety_interlock_tb.sv ***
`timescale 1ns/100ps
module crane_safety_interlock_tb
  import crane_pkg::*;
;
  localparam int TRIP = 8;
  localparam logic [8:0] HD = 9'h100, HU = 9'h080, BD = 9'h040, BU = 9'h020;
  localparam logic [8:0] EI = 9'h010, EO = 9'h008, RCW = 9'h002;
  logic          clk = 1'h0;
  logic          srst = 1'h1;
  logic [7:0]    awaddr = 8'h00, araddr = 8'h00;
  logic          awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0]   wdata = 32'h0;
  logic [3:0]    wstrb = 4'h0;
  logic          awready, wready, bvalid, arready, rvalid, irq, pump, load_closed, block_closed;
  logic [1:0]    bresp, rresp;
  logic [31:0]   rdata, active_codes, histogram_codes;
  function_set_t toggles = '0, fn_out;
  link_status_t  link = '0;
  logic [5:0]    sensor_faults = 6'h00;
  logic [8:0]    output_faults = 9'h000;
  logic          weight_lifted = 1'h0, over_press = 1'h0;
  int            error_cnt = 0, compares = 0;

  // Short trip filter keeps the run brief
  crane_interlock #(.TRIP_CYCLES(TRIP)) dut_u (
    .clk(clk), .srst(srst), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .load_sensor_closed(load_closed), .anti_two_block_switch(block_closed),
    .toggles(toggles), .link(link), .sensor_faults(sensor_faults),
    .output_faults(output_faults), .fn_out(fn_out), .pump(pump),
    .active_codes(active_codes), .histogram_codes(histogram_codes), .irq(irq));

  crane_far_side far_u (.weight_lifted(weight_lifted), .over_press(over_press),
    .load_closed(load_closed), .block_closed(block_closed));

  // Free-running system clock
  always #50 clk = ~clk;

  task automatic complete_run;
    if (error_cnt == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk

  task automatic chk_out(input logic [8:0] e, input logic p);
    chk({22'h0, fn_out, pump}, {22'h0, e, p});
  endtask : chk_out

  // Lets registered outputs settle before sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  // Master holds each channel until its own handshake edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int i;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (awready === 1'h1) awvalid <= 1'h0;
      if (wready === 1'h1) wvalid <= 1'h0;
      if (bvalid === 1'h1) break;
    end
    if (i == 50) begin
      error_cnt++;
      complete_run();
    end
    rsp = bresp;
    bready <= 1'h0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int i;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (arready === 1'h1) arvalid <= 1'h0;
      if (rvalid === 1'h1) break;
    end
    if (i == 50) begin
      error_cnt++;
      complete_run();
    end
    d = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask : rd

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : wreg

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    rd(a, d, r);
    chk(d, e);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rchk

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    chk(active_codes, 32'h0);
    chk_out(9'h000, 1'h0);
    rchk(ADDR_CTRL, 32'h0);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rd(8'h18, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
    wr(8'h18, 32'hffffffff, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
  endtask : t_reset

  task automatic t_overload;
    @(posedge clk) toggles <= function_set_t'(HU | EO | BU | EI | RCW | BD);
    tick(2);
    chk_out(HU | EO | BU | EI | RCW | BD, 1'h1);
    @(posedge clk) over_press <= 1'h1;
    tick(2);
    chk_out(BU | EI | RCW | BD, 1'h1);
    tick(TRIP + 2);
    chk_out(BU | EI | RCW, 1'h1);
    rchk(ADDR_LIVE, 32'h5);
    @(posedge clk) over_press <= 1'h0;
    toggles <= '0;
    tick(3);
  endtask : t_overload

  task automatic t_filter;
    @(posedge clk) toggles <= function_set_t'(BD);
    @(posedge clk) over_press <= 1'h1;
    repeat (TRIP - 1) @(posedge clk);
    over_press <= 1'h0;
    tick(3);
    chk_out(BD, 1'h1);
    @(posedge clk) over_press <= 1'h1;
    tick(TRIP);
    chk_out(BD, 1'h1);
    tick(1);
    chk_out(9'h000, 1'h0);
    @(posedge clk) over_press <= 1'h0;
    toggles <= '0;
  endtask : t_filter

  task automatic t_block;
    @(posedge clk) toggles <= function_set_t'(BD | HU);
    weight_lifted <= 1'h1;
    tick(3);
    chk_out(9'h000, 1'h0);
    wreg(ADDR_CTRL, 32'h1);
    tick(2);
    chk_out(BD, 1'h1);
    wreg(ADDR_CTRL, 32'h0);
    @(posedge clk) weight_lifted <= 1'h0;
    toggles <= function_set_t'(HU);
    tick(3);
    chk_out(HU, 1'h1);
    @(posedge clk) toggles <= function_set_t'(HU | HD);
    tick(2);
    chk_out(9'h000, 1'h0);
    @(posedge clk) toggles <= function_set_t'(HD);
    tick(2);
    chk_out(HD, 1'h1);
  endtask : t_block

  task automatic t_sensor;
    int i;
    @(posedge clk) toggles <= function_set_t'(HU | EO | BD);
    for (i = 0; i < SENSOR_CODES; i++) begin
      @(posedge clk) sensor_faults <= 6'h01 << i;
      tick(3);
      chk(active_codes, 32'h1 << (CODE_SENSOR_LO + i));
      chk_out(9'h000, 1'h0);
      @(posedge clk) sensor_faults <= 6'h00;
      wreg(ADDR_FAULTS, 32'hffffffff);
    end
    wreg(ADDR_CTRL, 32'h2);
    @(posedge clk) sensor_faults <= 6'h04;
    toggles <= function_set_t'(HU | EO | BD | BU);
    tick(3);
    chk_out(BD | BU, 1'h1);
    wreg(ADDR_CTRL, 32'h0);
    tick(2);
    chk_out(BU, 1'h1);
    @(posedge clk) toggles <= '0;
    sensor_faults <= 6'h00;
    tick(3);
    rchk(ADDR_FAULTS, 32'h40);
    wreg(ADDR_FAULTS, 32'h40);
    tick(2);
    chk(active_codes, 32'h0);
  endtask : t_sensor

  task automatic t_outputs;
    int i;
    for (i = 0; i < OUT_CODES; i++) begin
      @(posedge clk) output_faults <= 9'h001 << i;
      tick(3);
      @(posedge clk) output_faults <= 9'h000;
      tick(3);
      chk(histogram_codes, 32'h1 << (CODE_OUT_LO + i));
      @(posedge clk) toggles <= function_set_t'(9'h001 << i);
      tick(3);
      chk(active_codes, 32'h0);
      @(posedge clk) toggles <= '0;
    end
  endtask : t_outputs

  task automatic t_link;
    int i;
    logic [4:0]  lv[4] = '{5'h02, 5'h04, 5'h08, 5'h18};
    logic [31:0] ev[4] = '{32'h00800000, 32'h00100000, 32'h00080000, 32'h0};
    for (i = 0; i < 4; i++) begin
      @(posedge clk) link <= link_status_t'(lv[i]);
      tick(4);
      chk(active_codes, ev[i]);
      chk(histogram_codes, ev[i]);
      @(posedge clk) link <= '0;
      wreg(ADDR_FAULTS, 32'hffffffff);
    end
    @(posedge clk) link <= link_status_t'(5'h01);
    tick(4);
    chk(active_codes, 32'h01000000);
    chk(histogram_codes, 32'h0);
    @(posedge clk) toggles <= function_set_t'(BU);
    tick(3);
    chk(histogram_codes, 32'h01000000);
    rchk(ADDR_HISTO, 32'h01000000);
    @(posedge clk) link <= '0;
    toggles <= '0;
    tick(3);
    chk(active_codes, 32'h0);
  endtask : t_link

  task automatic t_irq;
    wreg(ADDR_IRQ_STAT, 32'h7);
    @(posedge clk) over_press <= 1'h1;
    tick(3);
    chk({31'h0, irq}, 32'h0);
    rchk(ADDR_IRQ_STAT, 32'h1);
    @(posedge clk) over_press <= 1'h0;
    wreg(ADDR_IRQ_MASK, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h1);
    wreg(ADDR_IRQ_STAT, 32'h1);
    tick(2);
    chk({31'h0, irq}, 32'h0);
  endtask : t_irq

  // Reset for 20 cycles, then one scenario after another
  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'h0;
    tick(2);
    t_reset();
    t_overload();
    t_filter();
    t_block();
    t_sensor();
    t_outputs();
    t_link();
    t_irq();
    complete_run();
  end
endmodule : crane_safety_interlock_tb
